// ---- rtl/bal_regs.svh ----
// Operation codes, flag positions and timing counts of the byte arithmetic logic unit
`ifndef BAL_REGS_SVH
`define BAL_REGS_SVH
`define BAL_OP_ADD 5'h00
`define BAL_OP_ADC 5'h01
`define BAL_OP_SUB 5'h02
`define BAL_OP_SUBC 5'h03
`define BAL_OP_SUBK 5'h04
`define BAL_OP_SBCK 5'h05
`define BAL_OP_WADD 5'h06
`define BAL_OP_WSUB 5'h07
`define BAL_OP_AND 5'h08
`define BAL_OP_ANDK 5'h09
`define BAL_OP_OR 5'h0a
`define BAL_OP_ORK 5'h0b
`define BAL_OP_SETM 5'h0c
`define BAL_OP_CLRM 5'h0d
`define BAL_OP_TEST 5'h0e
`define BAL_OP_XOR 5'h0f
`define BAL_OP_INV 5'h10
`define BAL_OP_NEGATE 5'h11
`define BAL_OP_PLUS1 5'h12
`define BAL_OP_MINUS1 5'h13
`define BAL_FLAG_C 0
`define BAL_FLAG_Z 1
`define BAL_FLAG_N 2
`define BAL_FLAG_V 3
`define BAL_FLAG_S 4
`define BAL_FLAG_H 5
`define BAL_FLAGS_RESET 6'h00
`define BAL_BYTE_CLOCKS 1
`define BAL_WORD_CLOCKS 2
`endif

// ---- rtl/bal_pkg.sv ----
// Types of the byte arithmetic logic unit
package bal_pkg;
    typedef enum logic [2:0] {
        BAL_IDLE = 3'b001,
        BAL_WORD_LOW = 3'b010,
        BAL_WORD_HIGH = 3'b100
    } bal_state_t;
    typedef struct packed {
        bal_state_t state;
        logic [7:0] result;
        logic [5:0] flags;
        logic done;
        logic wr_lo;
        logic wr_hi;
        logic [7:0] word_hi;
        logic [7:0] word_k;
        logic word_sub;
        logic word_carry;
        logic word_zero_lo;
    } bal_core_t;
endpackage

// ---- rtl/bal_flag_if.sv ----
// Flag update carrier between the datapath and the status flag holder
`timescale 1ns/1ps
interface bal_flag_if;
    logic [5:0] flags_next;
    logic [5:0] flags_mask;
    logic update;
    logic [5:0] flags;
    modport src (output flags_next, output flags_mask, output update, input flags);
    modport dst (input flags_next, input flags_mask, input update, output flags);
endinterface

// ---- rtl/bal_flag_hold.sv ----
// Status flag holder updating only the selected flags
`timescale 1ns/1ps
`include "bal_regs.svh"
module bal_flag_hold (
    input wire logic clock,
    input wire logic rst,
    bal_flag_if.dst fl
);
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    always_comb begin
        flags_next = flags_reg;
        if (fl.update) begin
            flags_next = (flags_reg & ~fl.flags_mask) | (fl.flags_next & fl.flags_mask);
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            flags_reg <= `BAL_FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end
    assign fl.flags = flags_reg;
endmodule

// ---- rtl/bal_alu.sv ----
// Byte arithmetic logic unit top
// Overview of operation
// - Sum two registers, optionally plus carry; flags Z,C,N,V,H; one clock.
// - Destination minus source, optionally minus carry; flags Z,C,N,V,H; one clock.
// - Destination minus immediate; flags Z,C,N,V,H; one clock.
// - Destination minus immediate minus carry; flags Z,C,N,V,H; one clock.
// - Add immediate to high:low word pair; writes both bytes; Z,C,N,V,S; two clocks.
// - Subtract immediate from high:low word pair; both bytes; Z,C,N,V,S; two clocks.
// - AND with register or immediate; flags Z,N,V; one clock.
// - OR with register or immediate; flags Z,N,V; one clock.
// - OR an immediate mask into destination; flags Z,N,V; one clock.
// - AND destination with inverted immediate mask; flags Z,N,V; one clock.
// - AND register with itself, value unchanged; flags Z,N,V; one clock.
`timescale 1ns/1ps
`include "bal_regs.svh"
module bal_alu (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [4:0] op,
    input wire logic [7:0] dst_val,
    input wire logic [7:0] src_val,
    input wire logic [7:0] imm_val,
    input wire logic [7:0] dst_hi_val,
    output logic busy,
    output logic [7:0] result,
    output logic result_wr_lo,
    output logic result_wr_hi,
    output logic done,
    output logic [5:0] flags
);
    bal_pkg::bal_core_t core_reg;
    bal_pkg::bal_core_t core_next;
    bal_flag_if fl ();

    bal_flag_hold u_flags (
        .clock(clock),
        .rst(rst),
        .fl(fl)
    );

    logic carry_in;
    logic [7:0] a;
    logic [7:0] b;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] r;
    logic [5:0] f;
    logic [5:0] m;
    logic upd;
    logic is_sub;
    logic use_arith;
    logic cin;
    logic [8:0] hsum9;
    logic [7:0] hres;
    logic wc;
    logic wv;
    logic wn;

    assign carry_in = fl.flags[`BAL_FLAG_C];

    always_comb begin
        core_next = core_reg;
        core_next.done = 1'b0;
        core_next.wr_lo = 1'b0;
        core_next.wr_hi = 1'b0;
        a = dst_val;
        b = 8'h00;
        cin = 1'b0;
        is_sub = 1'b0;
        use_arith = 1'b0;
        r = 8'h00;
        f = 6'h00;
        m = 6'h00;
        upd = 1'b0;
        sum9 = 9'h000;
        sum5 = 5'h00;
        hsum9 = 9'h000;
        hres = 8'h00;
        wc = 1'b0;
        wv = 1'b0;
        wn = 1'b0;
        case (core_reg.state)
            bal_pkg::BAL_IDLE: begin
                if (start) begin
                    case (op)
                        `BAL_OP_ADD, `BAL_OP_ADC: begin
                            b = src_val;
                            cin = (op == `BAL_OP_ADC) & carry_in;
                            use_arith = 1'b1;
                        end
                        `BAL_OP_SUB, `BAL_OP_SUBC: begin
                            b = src_val;
                            cin = (op == `BAL_OP_SUBC) & carry_in;
                            is_sub = 1'b1;
                            use_arith = 1'b1;
                        end
                        `BAL_OP_SUBK, `BAL_OP_SBCK: begin
                            b = imm_val;
                            cin = (op == `BAL_OP_SBCK) & carry_in;
                            is_sub = 1'b1;
                            use_arith = 1'b1;
                        end
                        `BAL_OP_NEGATE: begin
                            a = 8'h00;
                            b = dst_val;
                            is_sub = 1'b1;
                            use_arith = 1'b1;
                        end
                        `BAL_OP_PLUS1, `BAL_OP_MINUS1: begin
                            b = 8'h01;
                            is_sub = (op == `BAL_OP_MINUS1);
                            use_arith = 1'b1;
                        end
                        default: begin
                            use_arith = 1'b0;
                        end
                    endcase
                    if (use_arith) begin
                        if (is_sub) begin
                            sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                            sum5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
                        end else begin
                            sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                            sum5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                        end
                        r = sum9[7:0];
                        f[`BAL_FLAG_C] = sum9[8];
                        f[`BAL_FLAG_H] = sum5[4];
                        if (is_sub) begin
                            f[`BAL_FLAG_V] = (a[7] ^ b[7]) & (a[7] ^ r[7]);
                        end else begin
                            f[`BAL_FLAG_V] = ~(a[7] ^ b[7]) & (a[7] ^ r[7]);
                        end
                        m = 6'h2f;
                        if (op == `BAL_OP_PLUS1 || op == `BAL_OP_MINUS1) begin
                            m = 6'h0e;
                        end
                    end else begin
                        case (op)
                            `BAL_OP_AND: r = dst_val & src_val;
                            `BAL_OP_ANDK: r = dst_val & imm_val;
                            `BAL_OP_OR: r = dst_val | src_val;
                            `BAL_OP_ORK: r = dst_val | imm_val;
                            `BAL_OP_SETM: r = dst_val | imm_val;
                            `BAL_OP_CLRM: r = dst_val & (8'hff - imm_val);
                            `BAL_OP_TEST: r = dst_val & dst_val;
                            `BAL_OP_XOR: r = dst_val ^ src_val;
                            `BAL_OP_INV: r = 8'hff - dst_val;
                            default: r = dst_val;
                        endcase
                        f[`BAL_FLAG_V] = 1'b0;
                        f[`BAL_FLAG_C] = 1'b1;
                        m = (op == `BAL_OP_INV) ? 6'h0f : 6'h0e;
                    end
                    f[`BAL_FLAG_Z] = (r == 8'h00);
                    f[`BAL_FLAG_N] = r[7];
                    if (op == `BAL_OP_WADD || op == `BAL_OP_WSUB) begin
                        core_next.state = bal_pkg::BAL_WORD_LOW;
                        core_next.word_hi = dst_hi_val;
                        core_next.word_k = imm_val;
                        core_next.word_sub = (op == `BAL_OP_WSUB);
                        if (op == `BAL_OP_WSUB) begin
                            hsum9 = {1'b0, dst_val} - {1'b0, imm_val};
                        end else begin
                            hsum9 = {1'b0, dst_val} + {1'b0, imm_val};
                        end
                        core_next.result = hsum9[7:0];
                        core_next.word_carry = hsum9[8];
                        core_next.word_zero_lo = (hsum9[7:0] == 8'h00);
                        core_next.wr_lo = 1'b1;
                    end else if (op <= `BAL_OP_MINUS1) begin
                        core_next.result = r;
                        core_next.flags = f;
                        core_next.wr_lo = (op != `BAL_OP_TEST);
                        core_next.done = 1'b1;
                        upd = 1'b1;
                    end
                end
            end
            bal_pkg::BAL_WORD_LOW: begin
                if (core_reg.word_sub) begin
                    hsum9 = {1'b0, core_reg.word_hi} - {8'h00, core_reg.word_carry};
                end else begin
                    hsum9 = {1'b0, core_reg.word_hi} + {8'h00, core_reg.word_carry};
                end
                hres = hsum9[7:0];
                wn = hres[7];
                if (core_reg.word_sub) begin
                    wv = core_reg.word_hi[7] & ~hres[7];
                    wc = hres[7] & ~core_reg.word_hi[7];
                end else begin
                    wv = ~core_reg.word_hi[7] & hres[7];
                    wc = ~hres[7] & core_reg.word_hi[7];
                end
                f[`BAL_FLAG_C] = wc;
                f[`BAL_FLAG_Z] = (hres == 8'h00) & core_reg.word_zero_lo;
                f[`BAL_FLAG_N] = wn;
                f[`BAL_FLAG_V] = wv;
                f[`BAL_FLAG_S] = wn ^ wv;
                m = 6'h1f;
                upd = 1'b1;
                core_next.result = hres;
                core_next.flags = f;
                core_next.wr_hi = 1'b1;
                core_next.done = 1'b1;
                core_next.state = bal_pkg::BAL_WORD_HIGH;
            end
            bal_pkg::BAL_WORD_HIGH: begin
                core_next.state = bal_pkg::BAL_IDLE;
            end
            default: begin
                core_next.state = bal_pkg::BAL_IDLE;
            end
        endcase
        if (core_reg.state == bal_pkg::BAL_WORD_HIGH) begin
            core_next.state = bal_pkg::BAL_IDLE;
        end
    end

    assign fl.flags_next = f;
    assign fl.flags_mask = m;
    assign fl.update = upd;

    always_ff @(posedge clock) begin
        if (rst) begin
            core_reg <= '{state: bal_pkg::BAL_IDLE, default: '0};
        end else begin
            core_reg <= core_next;
        end
    end

    assign busy = (core_reg.state == bal_pkg::BAL_WORD_LOW);
    assign result = core_reg.result;
    assign result_wr_lo = core_reg.wr_lo;
    assign result_wr_hi = core_reg.wr_hi;
    assign done = core_reg.done;
    assign flags = fl.flags;
endmodule

// ---- dv/bal_regfile_model.sv ----
// Working register file model capturing unit results
`timescale 1ns/1ps
module bal_regfile_model (
    input wire logic clock,
    input wire logic [7:0] result,
    input wire logic result_wr_lo,
    input wire logic result_wr_hi,
    output logic [7:0] lo_q,
    output logic [7:0] hi_q
);
    always_ff @(posedge clock) begin
        if (result_wr_lo) lo_q <= result;
        if (result_wr_hi) hi_q <= result;
    end
endmodule

// ---- dv/bal_alu_monitor.sv ----
// Port checker of the byte arithmetic logic unit
`timescale 1ns/1ps
`include "bal_regs.svh"
module bal_alu_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [4:0] op,
    input wire logic [7:0] dst_val,
    input wire logic [7:0] src_val,
    input wire logic [7:0] imm_val,
    input wire logic [7:0] dst_hi_val,
    input wire logic busy,
    input wire logic [7:0] result,
    input wire logic result_wr_lo,
    input wire logic result_wr_hi,
    input wire logic done,
    input wire logic [5:0] flags
);
    logic rec_reg;
    logic acc;
    always_ff @(posedge clock) rec_reg <= !rst && done && result_wr_hi;
    assign acc = start && !busy && !rec_reg && !(done && result_wr_hi);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    word_seq_a:
    assert property (acc && (op == `BAL_OP_WADD || op == `BAL_OP_WSUB) |=> busy && result_wr_lo
        && !done ##1 done && result_wr_hi && !busy) else $error("word op timing wrong");
    hi_pair_a:
    assert property (result_wr_hi |-> done && $past(result_wr_lo)) else $error("high byte alone");
    test_nowr_a:
    assert property (acc && op == `BAL_OP_TEST |=> done && !result_wr_lo) else $error("test wrote");
    flag_hold_a:
    assert property ($changed(flags) |-> done) else $error("flags moved without done");
    carry_keep_a:
    assert property (acc && (op == `BAL_OP_PLUS1 || op == `BAL_OP_MINUS1) |=>
        flags[`BAL_FLAG_C] == $past(flags[`BAL_FLAG_C])) else $error("carry changed");
    logic_v_a:
    assert property (acc && op >= `BAL_OP_AND && op <= `BAL_OP_INV |=> !flags[`BAL_FLAG_V])
        else $error("logic op left overflow set");
    inv_val_a:
    assert property (acc && op == `BAL_OP_INV |=> flags[`BAL_FLAG_C] && result == ~$past(dst_val))
        else $error("inversion wrong");
    add_val_a:
    assert property (acc && op == `BAL_OP_ADD |=> done && result == $past(dst_val) + $past(src_val))
        else $error("sum wrong");
    clrm_val_a:
    assert property (acc && op == `BAL_OP_CLRM |=> result == ($past(dst_val) & ~$past(imm_val)))
        else $error("mask clear wrong");
    word_c: cover property (acc && op == `BAL_OP_WADD);
    test_c: cover property (acc && op == `BAL_OP_TEST);
    pair_c: cover property (done ##1 done);
endmodule

// ---- dv/bal_alu_tb_top.sv ----
// Self-checking bench of the byte arithmetic logic unit
`timescale 1ns/1ps
`include "bal_regs.svh"
module byte_arith_logic_unit_tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [4:0] op = 5'h00;
    logic [7:0] dst_val = 8'h00;
    logic [7:0] src_val = 8'h00;
    logic [7:0] imm_val = 8'h00;
    logic [7:0] dst_hi_val = 8'h00;
    logic busy, result_wr_lo, result_wr_hi, done;
    logic [7:0] result, lo_q, hi_q, el, eh;
    logic [5:0] flags, ef;
    logic [5:0] mf = 6'h00;
    int miscompares = 0;
    int samples_checked = 0;
    bal_alu dut (.clock(clock), .rst(rst), .start(start), .op(op), .dst_val(dst_val),
        .src_val(src_val), .imm_val(imm_val), .dst_hi_val(dst_hi_val), .busy(busy),
        .result(result), .result_wr_lo(result_wr_lo), .result_wr_hi(result_wr_hi),
        .done(done), .flags(flags));
    bal_regfile_model rf (.clock(clock), .result(result), .result_wr_lo(result_wr_lo),
        .result_wr_hi(result_wr_hi), .lo_q(lo_q), .hi_q(hi_q));
    initial forever #5 clock = ~clock;
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic calc(input logic [4:0] o, input logic [7:0] d, s, k, h);
        logic [8:0] t;
        logic [16:0] w;
        logic [7:0] a, b;
        logic ci, v, sb;
        ci = (o == `BAL_OP_ADC || o == 5'h03 || o == `BAL_OP_SBCK) ? mf[0] : 1'b0;
        sb = (o >= 5'h02 && o <= 5'h05) || o == `BAL_OP_NEGATE;
        a = (o == `BAL_OP_NEGATE) ? 8'h00 : d;
        b = (o == `BAL_OP_NEGATE) ? d : ((o == `BAL_OP_SUBK || o == `BAL_OP_SBCK) ? k : s);
        t = sb ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
        ef = mf;
        ef[5] = sb ? ({1'b0, a[3:0]} < b[3:0] + ci) : ({1'b0, a[3:0]} + b[3:0] + ci > 5'h0f);
        v = sb ? (a[7] != b[7]) && (t[7] != a[7]) : (a[7] == b[7]) && (t[7] != a[7]);
        ef[0] = t[8];
        case (o)
            `BAL_OP_AND: t[7:0] = d & s;
            `BAL_OP_ANDK: t[7:0] = d & k;
            `BAL_OP_OR: t[7:0] = d | s;
            `BAL_OP_ORK, `BAL_OP_SETM: t[7:0] = d | k;
            `BAL_OP_CLRM: t[7:0] = d & ~k;
            `BAL_OP_TEST: t[7:0] = d;
            `BAL_OP_XOR: t[7:0] = d ^ s;
            `BAL_OP_INV: t[7:0] = ~d;
            `BAL_OP_PLUS1: t[7:0] = d + 8'h01;
            `BAL_OP_MINUS1: t[7:0] = d - 8'h01;
            default: ;
        endcase
        if (o >= 5'h08 && o != `BAL_OP_NEGATE) begin
            ef[5] = mf[5];
            ef[0] = (o == `BAL_OP_INV) || mf[0];
            v = (o == `BAL_OP_PLUS1) ? d == 8'h7f : (o == `BAL_OP_MINUS1) && d == 8'h80;
        end
        el = t[7:0];
        ef[3:1] = {v, t[7], t[7:0] == 8'h00};
        if (o == `BAL_OP_WADD || o == `BAL_OP_WSUB) begin
            w = (o == `BAL_OP_WADD) ? {1'b0, h, d} + k : {1'b0, h, d} - k;
            v = (o == `BAL_OP_WADD) ? !h[7] && w[15] : h[7] && !w[15];
            {el, eh} = {w[7:0], w[15:8]};
            ef = {mf[5], w[15] ^ v, v, w[15], w[15:0] == 16'h0000, w[16]};
        end
    endtask
    task automatic run(input logic [4:0] o, input logic [7:0] d, s, k, h);
        logic wd;
        wd = o == `BAL_OP_WADD || o == `BAL_OP_WSUB;
        calc(o, d, s, k, h);
        @(negedge clock);
        {start, op, dst_val, src_val, imm_val, dst_hi_val} = {1'b1, o, d, s, k, h};
        @(negedge clock);
        start = 1'b0;
        if (wd) begin
            chk(busy && result_wr_lo && !done && result === el, "word low byte");
            @(negedge clock);
        end
        chk(done && result_wr_lo == (o != `BAL_OP_TEST && !wd) && wd == result_wr_hi, "pulses");
        chk(flags === ef && (o == `BAL_OP_TEST || result === (wd ? eh : el)), "result or flags");
        mf = ef;
        @(negedge clock);
        if (o != `BAL_OP_TEST) chk(lo_q === el && (!wd || hi_q === eh), "register file");
        @(negedge clock);
    endtask
    task automatic t_arith;
        run(`BAL_OP_ADD, 8'h0f, 8'h01, 8'h00, 8'h00);
        run(`BAL_OP_ADD, 8'h80, 8'h80, 8'h00, 8'h00);
        run(`BAL_OP_ADC, 8'h7f, 8'h00, 8'h00, 8'h00);
        run(`BAL_OP_SUB, 8'h10, 8'h01, 8'h00, 8'h00);
        run(`BAL_OP_SUBK, 8'h05, 8'h00, 8'h05, 8'h00);
        run(5'h03, 8'h00, 8'h01, 8'h00, 8'h00);
        run(`BAL_OP_SBCK, 8'h20, 8'h00, 8'h0f, 8'h00);
        $display("test arith done");
    endtask
    task automatic t_word;
        run(`BAL_OP_WADD, 8'hff, 8'h00, 8'h01, 8'h00);
        run(`BAL_OP_WADD, 8'hff, 8'h00, 8'h01, 8'h7f);
        run(`BAL_OP_WSUB, 8'h00, 8'h00, 8'h01, 8'h00);
        run(`BAL_OP_WSUB, 8'h01, 8'h00, 8'h01, 8'h00);
        $display("test word done");
    endtask
    task automatic t_logic;
        for (int i = 8; i < 20; i++) begin
            run(5'(i), 8'h96, 8'h3c, 8'h0f, 8'h00);
        end
        run(`BAL_OP_NEGATE, 8'h00, 8'h00, 8'h00, 8'h00);
        run(`BAL_OP_PLUS1, 8'h7f, 8'h00, 8'h00, 8'h00);
        run(`BAL_OP_MINUS1, 8'h80, 8'h00, 8'h00, 8'h00);
        run(`BAL_OP_TEST, 8'h00, 8'h00, 8'h00, 8'h00);
        $display("test logic done");
    endtask
    task automatic t_order;
        calc(`BAL_OP_ADD, 8'h01, 8'h02, 8'h00, 8'h00);
        @(negedge clock);
        {start, op, dst_val, src_val} = {1'b1, `BAL_OP_ADD, 16'h0102};
        @(negedge clock);
        chk(done && result === el && flags === ef, "first of pair");
        mf = ef;
        op = `BAL_OP_XOR;
        calc(`BAL_OP_XOR, 8'h01, 8'h02, 8'h00, 8'h00);
        @(negedge clock);
        chk(done && result === el && flags === ef, "second of pair");
        mf = ef;
        {op, dst_val, imm_val, dst_hi_val} = {`BAL_OP_WADD, 24'hff0112};
        calc(`BAL_OP_WADD, 8'hff, 8'h02, 8'h01, 8'h12);
        @(negedge clock);
        op = `BAL_OP_ADD;
        @(negedge clock);
        start = 1'b0;
        chk(done && result === eh && flags === ef, "word after byte");
        repeat (2) @(negedge clock);
        chk(!done && lo_q === el, "start while busy");
        {start, op} = {1'b1, 5'h1f};
        @(negedge clock);
        start = 1'b0;
        chk(!done && !result_wr_lo && flags === ef, "unknown op");
        $display("test order done");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk(!busy && !done && flags === 6'h00, "reset state");
        rst = 1'b0;
        t_arith;
        t_word;
        t_logic;
        t_order;
        final_report;
    end
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        final_report;
    end
endmodule
bind bal_alu bal_alu_monitor mon (.clock(clock), .rst(rst), .start(start), .op(op),
    .dst_val(dst_val), .src_val(src_val), .imm_val(imm_val), .dst_hi_val(dst_hi_val),
    .busy(busy), .result(result), .result_wr_lo(result_wr_lo),
    .result_wr_hi(result_wr_hi), .done(done), .flags(flags));
